/* logic/oopll_pkg.sv */
/*
 offset oscillator pll counters: shared constants and types.
 assumes a 20 MHz system clock on both ends.
*/
package oopll_pkg;
   // ==========================================================
   // dividers and tuning
   localparam int REF_DIV         = 1000;
   localparam int PRESCALE_LO     = 100;
   localparam int PRESCALE_HI     = 101;
   localparam int OUT_DIV         = 100;
   localparam int N_CENTER        = 45500;
   localparam int N_MIN           = 44500;
   localparam int N_MAX           = 46500;
   localparam int N_W             = 16;
   localparam int OFS_W           = 12;
   localparam int WORD_W          = 12;
   localparam int LOCK_ERR_MAX    = 4;
   // ==========================================================
   // timing
   localparam int CLK_HZ          = 20000000;
   localparam int LINK_HZ         = 750000;
   localparam int LINK_HALF       = CLK_HZ / (2 * LINK_HZ);
   localparam int CHECK_PULSE     = 8;
   // ==========================================================
   // controller registers
   localparam logic [3:0] REG_OFFSET   = 4'h0;
   localparam logic [3:0] REG_CONTROL  = 4'h1;
   localparam logic [3:0] REG_STATUS   = 4'h2;
   localparam logic [3:0] REG_CLEAR    = 4'h3;
   localparam logic [3:0] REG_ENABLE   = 4'h4;
   localparam int CTL_SEND        = 0;
   localparam int CTL_SELFTEST    = 1;
   localparam int CTL_MODE_LSB    = 2;
   localparam int EV_UNLOCK       = 0;
   localparam int EV_CHECK_OK     = 1;
   localparam int EV_CHECK_FAIL   = 2;
   localparam int EV_W            = 3;
   typedef enum logic [2:0] {
      MODE_LSB = 3'h0, MODE_USB = 3'h1, MODE_ISB = 3'h2,
      MODE_CW  = 3'h3, MODE_AM  = 3'h4, MODE_FM  = 3'h5
   } oopll_mode_type;
endpackage

/* logic/oopll_link_if.sv */
/*
 link between receiver controller and offset oscillator counters.
 assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
interface oopll_link_if;
   logic ser_clk;
   logic ser_data;
   logic load_enable;
   logic osc_disable;
   logic lock_n;
   logic data_check_output;
   modport device (input ser_clk, input ser_data, input load_enable,
                   input osc_disable, output lock_n,
                   output data_check_output);
   modport ctrl (output ser_clk, output ser_data, output load_enable,
                 output osc_disable, input lock_n,
                 input data_check_output);
endinterface // oopll_link_if

/* logic/oopll_device.sv */
/*
 offset oscillator counters: reference divider, divide-by-n with
 dual-modulus prescaler, phase-frequency comparator, output /100,
 serial tuning load, lock and data check.
 assumes ref_in and vco_in are digital clocks slower than clk/2 and
 the controller follows the link conventions.
*/
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module oopll_device
   import oopll_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   oopll_link_if.device            link,
   input  wire logic               ref_in,
   input  wire logic               vco_in,
   output logic                    ref_spare_out,
   output logic                    injection_out,
   output logic                    pump_up_output_n,
   output logic                    pump_down_output_n,
   output logic                    osc_run,
   output logic                    prescale_mod
);
   import oopll_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]       ref_s;
      logic [1:0]       vco_s;
      logic [1:0]       sck_s;
      logic [1:0]       en_s;
      logic [1:0]       dis_s;
      logic [1:0]       dat_s;
      logic             ref_p;
      logic             vco_p;
      logic             sck_p;
      logic             en_p;
      logic [9:0]       ref_cnt;
      logic [6:0]       pre_cnt;
      logic [8:0]       prog_cnt;
      logic [6:0]       out_cnt;
      logic             out_q;
      logic [WORD_W-1:0] shift;
      logic [4:0]       nbits;
      logic [N_W-1:0]   n_act;
      logic             up;
      logic             dn;
      logic [2:0]       err_cnt;
      logic             lock_n;
      logic [3:0]       chk_cnt;
      logic             ref_out;
      logic             pmod;
      logic             chk_q;
   } oopll_dev_type;

   oopll_dev_type s_q, s_d;

   // ==========================================================
   // tuning word to division factor
   function automatic logic [N_W-1:0] calc_n(input logic [OFS_W-1:0] o);
      logic signed [N_W+1:0] v;
      v = (N_W+2)'(N_CENTER) - (N_W+2)'($signed(o));
      if (v < (N_W+2)'(N_MIN)) v = (N_W+2)'(N_MIN);
      if (v > (N_W+2)'(N_MAX)) v = (N_W+2)'(N_MAX);
      return v[N_W-1:0];
   endfunction

   // ==========================================================
   // decoded strobes
   logic ref_tick;
   logic vco_tick;
   logic sck_rise;
   logic en_fall;
   logic blocked;
   logic fb_tick;
   logic [N_W-1:0] n_new;
   logic [8:0] n_hi;
   logic [6:0] n_lo;

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      // input sampling: two flops on every pin before use
      s_d.ref_s = {s_q.ref_s[0], ref_in};
      s_d.vco_s = {s_q.vco_s[0], vco_in};
      s_d.sck_s = {s_q.sck_s[0], link.ser_clk};
      s_d.en_s  = {s_q.en_s[0], link.load_enable};
      s_d.dis_s = {s_q.dis_s[0], link.osc_disable};
      s_d.dat_s = {s_q.dat_s[0], link.ser_data};
      s_d.ref_p = s_q.ref_s[1];
      s_d.vco_p = s_q.vco_s[1];
      s_d.sck_p = s_q.sck_s[1];
      s_d.en_p  = s_q.en_s[1];
      s_d.ref_out = s_q.ref_s[1];
      blocked  = s_q.dis_s[1];
      ref_tick = s_q.ref_s[1] & ~s_q.ref_p;
      vco_tick = s_q.vco_s[1] & ~s_q.vco_p & ~blocked;
      sck_rise = s_q.sck_s[1] & ~s_q.sck_p;
      en_fall  = ~s_q.en_s[1] & s_q.en_p;
      fb_tick  = 1'b0;
      n_new    = calc_n(s_q.shift);
      n_hi     = 9'(s_q.n_act / N_W'(PRESCALE_LO));
      n_lo     = 7'(s_q.n_act % N_W'(PRESCALE_LO));

      // ==========================================================
      // reference /1000
      if (ref_tick) begin
         if (s_q.ref_cnt == 10'(REF_DIV - 1)) s_d.ref_cnt = '0;
         else s_d.ref_cnt = s_q.ref_cnt + 10'h001;
      end

      // ==========================================================
      // pulse swallow: prescale 101 for n_lo cycles, then 100
      if (vco_tick) begin
         if (s_q.pre_cnt == ((s_q.prog_cnt < 9'(n_lo)) ?
             7'(PRESCALE_HI - 1) : 7'(PRESCALE_LO - 1))) begin
            s_d.pre_cnt = '0;
            if (s_q.prog_cnt == n_hi - 9'h001) begin
               s_d.prog_cnt = '0;
               fb_tick = 1'b1;
            end else s_d.prog_cnt = s_q.prog_cnt + 9'h001;
         end else s_d.pre_cnt = s_q.pre_cnt + 7'h01;
         // injection /100
         if (s_q.out_cnt == 7'(OUT_DIV/2 - 1)) begin
            s_d.out_cnt = '0;
            s_d.out_q = ~s_q.out_q;
         end else s_d.out_cnt = s_q.out_cnt + 7'h01;
      end

      // ==========================================================
      // phase-frequency comparator
      if (ref_tick && s_q.ref_cnt == 10'(REF_DIV - 1)) s_d.up = 1'b1;
      if (fb_tick) s_d.dn = 1'b1;
      if (s_d.up && s_d.dn) begin
         s_d.up = 1'b0;
         s_d.dn = 1'b0;
      end

      // ==========================================================
      // lock: lost after consecutive one-sided errors
      // forced high while disabled: the loop cannot track then
      if (ref_tick && s_q.ref_cnt == 10'(REF_DIV - 1)) begin
         if (s_q.up || s_q.dn) begin
            if (s_q.err_cnt != 3'(LOCK_ERR_MAX)) s_d.err_cnt = s_q.err_cnt + 3'h1;
         end else s_d.err_cnt = '0;
      end
      s_d.lock_n = blocked | (s_d.err_cnt == 3'(LOCK_ERR_MAX));

      // ==========================================================
      // serial tuning load
      // partial or out-of-range words are dropped, never clamped in
      if (s_q.en_s[1] && sck_rise) begin
         s_d.shift = {s_q.shift[WORD_W-2:0], s_q.dat_s[1]};
         if (s_q.nbits != 5'h1f) s_d.nbits = s_q.nbits + 5'h01;
      end
      if (en_fall) begin
         if (s_q.nbits == 5'(WORD_W) && n_new == N_W'(N_CENTER -
             $signed({{(32-OFS_W){s_q.shift[OFS_W-1]}}, s_q.shift}))) begin
            s_d.n_act = n_new;
            s_d.chk_cnt = 4'(CHECK_PULSE);
         end
         s_d.nbits = '0;
      end else if (s_q.chk_cnt != '0) s_d.chk_cnt = s_q.chk_cnt - 4'h1;
      if (~s_q.en_s[1] && ~en_fall) s_d.nbits = '0;

      // ==========================================================
      // registered copies for outputs
      s_d.pmod  = s_d.prog_cnt < 9'(n_lo);
      s_d.chk_q = s_d.chk_cnt != '0;
   end

   // ==========================================================
   // registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.n_act <= N_W'(N_CENTER);
         s_q.lock_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all straight from flops
   assign ref_spare_out      = s_q.ref_out;
   assign injection_out      = s_q.out_q;
   assign pump_up_output_n   = ~s_q.up;
   assign pump_down_output_n = ~s_q.dn;
   assign osc_run            = ~s_q.dis_s[1];
   assign prescale_mod       = s_q.pmod;
   assign link.lock_n        = s_q.lock_n;
   assign link.data_check_output = s_q.chk_q;
endmodule // oopll_device

/* logic/oopll_ctrl.sv */
/*
 receiver controller end: shifts tuning words, drives disable,
 watches lock and runs the data check during self-test.
 assumes the device shares clk; link inputs are still resynchronised.
*/
`timescale 1ns/1ps
module oopll_ctrl
   import oopll_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   oopll_link_if.ctrl              link,
   input  wire logic [3:0]         addr,
   input  wire logic [15:0]        wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output logic [15:0]             rdata,
   output logic                    irq,
   output logic                    fault_lamp
);
   import oopll_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_CLOSE = 2'b10, ST_WAIT = 2'b11
   } oopll_st_type;

   typedef struct packed {
      oopll_st_type       st;
      logic [OFS_W-1:0]   offset, sh;
      oopll_mode_type     mode;
      logic               selftest, sclk, en, dat;
      logic               dis;
      logic [4:0]         div, bits;
      logic [5:0]         wait_cnt;
      logic [1:0]         lock_s, chk_s;
      logic [EV_W-1:0]    stat, ena;
      logic [15:0]        rdata;
      logic               irq;
   } oopll_ctl_type;

   oopll_ctl_type s_q, s_d;
   logic [EV_W-1:0] ev;

   always_comb begin
      s_d = s_q;
      ev = '0;
      s_d.lock_s = {s_q.lock_s[0], link.lock_n};
      s_d.chk_s  = {s_q.chk_s[0], link.data_check_output};
      if (s_q.lock_s[1] && s_q.mode <= MODE_CW) ev[EV_UNLOCK] = 1'b1;
      s_d.rdata = '0;
      if (rd) begin
         unique case (addr)
            REG_OFFSET:  s_d.rdata = 16'(s_q.offset);
            REG_CONTROL: s_d.rdata = {11'h000, s_q.mode, s_q.selftest,
                                      s_q.st != ST_IDLE};
            REG_STATUS:  s_d.rdata = 16'(s_q.stat);
            REG_ENABLE:  s_d.rdata = 16'(s_q.ena);
            default:     s_d.rdata = '0;
         endcase
      end
      if (wr && addr == REG_OFFSET) s_d.offset = wdata[OFS_W-1:0];
      if (wr && addr == REG_ENABLE) s_d.ena = wdata[EV_W-1:0];
      if (wr && addr == REG_CONTROL) begin
         s_d.selftest = wdata[CTL_SELFTEST];
         s_d.mode = oopll_mode_type'(wdata[CTL_MODE_LSB +: 3]);
      end
      unique case (s_q.st)
         ST_IDLE: if (wr && addr == REG_CONTROL && wdata[CTL_SEND]) begin
            s_d.st = ST_SHIFT;
            s_d.sh = s_q.offset;
            s_d.en = 1'b1;
            s_d.bits = 5'(WORD_W);
            s_d.div = '0;
            s_d.sclk = 1'b0;
            s_d.dat = s_q.offset[OFS_W-1];
         end
         ST_SHIFT: begin
            if (s_q.div == 5'(LINK_HALF - 1)) begin
               s_d.div = '0;
               s_d.sclk = ~s_q.sclk;
               if (s_q.sclk) begin
                  s_d.sh = {s_q.sh[OFS_W-2:0], 1'b0};
                  s_d.dat = s_q.sh[OFS_W-2];
                  s_d.bits = s_q.bits - 5'h01;
                  if (s_q.bits == 5'h01) s_d.st = ST_CLOSE;
               end
            end else s_d.div = s_q.div + 5'h01;
         end
         ST_CLOSE: begin
            s_d.en = 1'b0;
            s_d.wait_cnt = '0;
            s_d.st = s_q.selftest ? ST_WAIT : ST_IDLE;
         end
         ST_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt + 6'h01;
            if (s_q.chk_s[1]) begin
               ev[EV_CHECK_OK] = 1'b1;
               s_d.st = ST_IDLE;
            end else if (s_q.wait_cnt == 6'h3f) begin
               ev[EV_CHECK_FAIL] = 1'b1;
               s_d.st = ST_IDLE;
            end
         end
      endcase
      // set wins over clear
      if (wr && addr == REG_CLEAR) s_d.stat = s_q.stat & ~wdata[EV_W-1:0];
      s_d.stat = s_d.stat | ev;
      s_d.irq = |(s_d.stat & s_d.ena);
      s_d.dis = s_d.mode > MODE_CW;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) s_q <= '0;
      else s_q <= s_d;
   end

   assign link.ser_clk     = s_q.sclk;
   assign link.ser_data    = s_q.dat;
   assign link.load_enable = s_q.en;
   assign link.osc_disable = s_q.dis;
   assign rdata      = s_q.rdata;
   assign irq        = s_q.irq;
   assign fault_lamp = s_q.stat[EV_UNLOCK];
endmodule // oopll_ctrl

/* tb/oopll_asserts.sv */
/*
 link checker for the offset oscillator counters.
 assumes both ends share clk and rst.
*/
`timescale 1ns/1ps
module oopll_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_enable,
   input wire logic osc_disable,
   input wire logic lock_n,
   input wire logic data_check_output
);
   // ==========================================================
   // helpers
   logic [4:0] hi_q;
   logic [4:0] bits_q;
   logic       sc_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_q   <= 5'h0;
         bits_q <= 5'h0;
         sc_q   <= 1'b0;
      end else begin
         hi_q   <= ser_clk ? hi_q + 5'h1 : 5'h0;
         bits_q <= !load_enable ? 5'h0 : bits_q + 5'(ser_clk && !sc_q);
         sc_q   <= ser_clk;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // properties
   sequence s_check;
      data_check_output [*8] ##1 !data_check_output;
   endsequence
   property p_rise_in_window;
      $rose(ser_clk) |-> load_enable;
   endproperty
   property p_data_steady;
      $rose(ser_clk) |-> $stable(ser_data);
   endproperty
   property p_twelve;
      $fell(load_enable) |-> bits_q == 5'hc;
   endproperty
   property p_half;
      $fell(ser_clk) && load_enable |-> hi_q == 5'hd;
   endproperty
   property p_en_pulse;
      $rose(load_enable) |=> load_enable [*8];
   endproperty
   property p_open_low;
      $rose(load_enable) |-> !ser_clk;
   endproperty
   property p_check_len;
      $rose(data_check_output) |-> s_check;
   endproperty
   property p_dis_lock;
      $rose(osc_disable) |-> ##[1:4] lock_n;
   endproperty
   property p_check_after;
      $rose(data_check_output) |-> !load_enable && $past(!load_enable, 2);
   endproperty
   a_rise_in_window: assert property (p_rise_in_window)
      else $error("serial clock rose outside window");
   a_data_steady: assert property (p_data_steady)
      else $error("serial data moved at clock rise");
   a_twelve: assert property (p_twelve)
      else $error("window held other than twelve bits");
   a_half: assert property (p_half)
      else $error("serial clock high time wrong");
   a_en_pulse: assert property (p_en_pulse)
      else $error("enable pulse too short");
   a_open_low: assert property (p_open_low)
      else $error("window opened with clock high");
   a_check_len: assert property (p_check_len)
      else $error("check pulse length wrong");
   a_dis_lock: assert property (p_dis_lock)
      else $error("lock indicator low while disabled");
   a_check_after: assert property (p_check_after)
      else $error("check pulse before window closed");
endmodule // oopll_asserts

/* tb/tb_top.sv */
/*
 bench for the offset oscillator counters, both ends joined.
 assumes the bench alone drives the register port, ref_in and vco_in.
*/
`timescale 1ns/1ps
module tb_top;
   import oopll_pkg::*;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, ref_in = 0, vco_in = 0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0, rdata, rv;
   logic        irq, fault_lamp, ref_spare_out, injection_out;
   logic        pu_n, pd_n, osc_run, prescale_mod, seen_chk = 0;
   logic [11:0] sh = 12'h0;
   logic [2:0]  hist = 3'h0;
   int          errors = 0, n_tests = 0;
   oopll_link_if link ();
   oopll_device i_oopll_device (.clk(clk), .rst(rst), .link(link),
      .ref_in(ref_in), .vco_in(vco_in), .ref_spare_out(ref_spare_out),
      .injection_out(injection_out), .pump_up_output_n(pu_n),
      .pump_down_output_n(pd_n), .osc_run(osc_run),
      .prescale_mod(prescale_mod));
   oopll_ctrl i_oopll_ctrl (.clk(clk), .rst(rst), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .fault_lamp(fault_lamp));
   oopll_asserts i_oopll_asserts (.clk(clk), .rst(rst),
      .ser_clk(link.ser_clk), .ser_data(link.ser_data),
      .load_enable(link.load_enable), .osc_disable(link.osc_disable),
      .lock_n(link.lock_n), .data_check_output(link.data_check_output));
   // ==========================================================
   // clocks and monitors
   initial forever #25 clk = ~clk;
   // 1 MHz reference, slow vco: real vco is far above clk
   always begin repeat (10) @(posedge clk); ref_in <= ~ref_in; end
   always begin repeat (4) @(posedge clk); vco_in <= ~vco_in; end
   always @(posedge clk) hist <= {hist[1:0], ref_in};
   always @(posedge clk) if (link.data_check_output) seen_chk <= 1'b1;
   always @(posedge link.ser_clk) begin
      if (link.load_enable) sh <= {sh[10:0], link.ser_data};
   end
   // ==========================================================
   // tasks
   task automatic check(input string nm, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask
   task automatic final_report;
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_send(input logic [11:0] ofs);
      int i;
      seen_chk = 1'b0;
      wr_reg(REG_ENABLE, 16'h1 << EV_CHECK_OK);
      wr_reg(REG_OFFSET, {{4{ofs[11]}}, ofs});
      rd_reg(REG_OFFSET);
      check("offset", rv, {4'h0, ofs});
      wr_reg(REG_CONTROL, 16'h3);
      for (i = 0; i < 300; i++) begin
         rd_reg(REG_CONTROL);
         if (rv[CTL_SEND] === 1'b0) break;
      end
      repeat (64) @(negedge clk);
      check("bits", 16'(sh), 16'(ofs));
      check("check pulse", 16'(seen_chk), 16'h1);
      rd_reg(REG_STATUS);
      check("status", 16'(rv[2:1]), 16'h1);
      check("irq", 16'(irq), 16'h1);
      wr_reg(REG_CLEAR, 16'h7);
      rd_reg(REG_STATUS);
      check("irq cleared", 16'(irq), 16'h0);
      check("lamp cleared", 16'(fault_lamp), 16'h0);
   endtask
   task automatic t_refuse;
      int i;
      seen_chk = 1'b0;
      wr_reg(REG_ENABLE, 16'h1 << EV_CHECK_FAIL);
      wr_reg(REG_OFFSET, 16'h0800);
      wr_reg(REG_CONTROL, 16'h3);
      for (i = 0; i < 300; i++) begin
         rd_reg(REG_CONTROL);
         if (rv[CTL_SEND] === 1'b0) break;
      end
      check("no pulse", 16'(seen_chk), 16'h0);
      rd_reg(REG_STATUS);
      check("fail status", 16'(rv[2:1]), 16'h2);
      check("fail irq", 16'(irq), 16'h1);
      wr_reg(REG_CLEAR, 16'h7);
   endtask
   task automatic t_mode;
      int  m;
      logic v;
      for (m = 0; m < 6; m++) begin
         wr_reg(REG_CONTROL, 16'(m) << CTL_MODE_LSB);
         repeat (4) @(negedge clk);
         check("disable", 16'(link.osc_disable), 16'(m > 3));
         check("osc run", 16'(osc_run), 16'(m <= 3));
         v = injection_out;
         repeat (900) @(negedge clk);
         if (m > 3) check("frozen", 16'(injection_out), 16'(v));
      end
      wr_reg(REG_CONTROL, 16'h0);
   endtask
   task automatic t_inj;
      int   c, s, k;
      logic pv, pi;
      c  = 0;
      s  = 0;
      pv = vco_in;
      pi = injection_out;
      for (k = 0; k < 3000 && s < 2; k++) begin
         @(negedge clk);
         if (injection_out && !pi) s++;
         if (vco_in && !pv && s == 1) c++;
         pi = injection_out;
         pv = vco_in;
         check("ref spare", 16'(ref_spare_out), 16'(hist[2]));
      end
      check("vco per injection", 16'(c), 16'(OUT_DIV));
   endtask
   task automatic t_pump;
      int   k;
      logic dn;
      dn = 1'b0;
      for (k = 0; k < 45000 && pu_n !== 1'b0; k++) begin
         @(negedge clk);
         if (pd_n !== 1'b1) dn = 1'b1;
      end
      check("pump up", 16'(pu_n), 16'h0);
      check("pump down", 16'(dn), 16'h0);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("lock", 16'(link.lock_n), 16'h1);
      check("pumps", 16'({pu_n, pd_n}), 16'h3);
      check("irq", 16'(irq), 16'h0);
      t_send(12'h1f4);
      t_send(12'hc19);
      t_refuse();
      t_mode();
      t_inj();
      t_pump();
      final_report();
   end
   initial begin
      #(80000 * 50);
      errors++;
      final_report();
   end
endmodule // tb_top
